// ===== design/usb_ep_hub_pkg.sv
package usb_ep_hub_pkg;
    // register indices; the bus byte address is four times the index
    localparam logic [15:0] IDX_EP2_CTRL = 16'h1fa3;
    localparam logic [15:0] IDX_EP1_CTRL = 16'h1fa4;
    localparam logic [15:0] IDX_HUB_STAT = 16'h1fc7;
    localparam logic [15:0] IDX_HUB_GLOBAL_STATE = 16'h1ffb;
    localparam logic [15:0] IDX_EP2_STAT = 16'h1fdb;
    localparam logic [15:0] IDX_EP1_STAT = 16'h1fdc;
    localparam int ADDR_W = 18;
    localparam logic [7:0] RESET_VALUE = 8'h00;
    // control/ack register bit positions
    localparam int CTL_TXC_ACK = 0;
    localparam int CTL_RXO_ACK = 1;
    localparam int CTL_STL_ACK = 3;
    localparam int CTL_TX_RDY = 4;
    localparam int CTL_HALT = 5;
    localparam int CTL_LAST = 6;
    // endpoint status bit positions
    localparam int ST_TXC = 0;
    localparam int ST_RXO = 1;
    localparam int ST_STL = 3;
    // global state bit positions
    localparam int GS_ADDR_EN = 0;
    localparam int GS_CONFIG = 1;
    localparam int GS_WAKE_EN = 2;
    localparam int GS_RESUME = 3;
    localparam int GS_SUSP = 4;
    // hub power status bit positions
    localparam int HS_LPL = 0;
    localparam int HS_OVI = 1;
    localparam int HS_LPC = 2;
    localparam int HS_OVC = 3;
    // handshake codes to the serial engine
    typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} hs_type;
endpackage

// ===== design/usb_ep_hub_regs.sv
// Decided for this implementation: register access over APB.
`timescale 1ns/1ps
// What this block does
// - set receive flag when out data stored
// - nak out tokens while receive flag set
// - fifo write blocked until firmware releases, except for an early setup
// - receive ack write clears receive flag
// - transmit complete set on in done
// - ack bits are one-shot write pulses
// - halt bit forces stall on next token
// - tx ready cleared on ack or iso sent
// - interrupt when ready cleared with complete
// - hub interrupt endpoint reports changes autonomously
// - hub endpoint naks when nothing changed
// - suspend flag mirrors suspended state
// - resume flag from upstream until downstream done
// - configured bit cleared by reset or config0
// - new address used from next transaction
// - hub status power lost and overcurrent
// - hub status change bits
// - stall-sent flag set after stall, ack clears
module usb_ep_hub_regs
    import usb_ep_hub_pkg::*;
#(
    parameter int NUM_EP = 2
) (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // apb slave
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [usb_ep_hub_pkg::ADDR_W-1:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    // serial engine, function endpoint events (index 0 = ep1, 1 = ep2)
    input wire logic [1:0] i_ep_out_token,
    input wire logic [1:0] i_ep_in_token,
    input wire logic [1:0] i_ep_iso,
    input wire logic [1:0] i_ep_out_stored,
    input wire logic [1:0] i_ep_in_acked,
    input wire logic [1:0] i_ep_iso_sent,
    input wire logic [1:0] i_ep_stall_sent,
    input wire logic [1:0] i_ep_irq_en,
    input wire logic i_early_setup,
    output usb_ep_hub_pkg::hs_type o_ep1_hs,
    output usb_ep_hub_pkg::hs_type o_ep2_hs,
    output logic [1:0] o_ep_fifo_wr_en,
    output logic [1:0] o_ep_tx_ready,
    output logic [1:0] o_ep_last_packet,
    output logic o_ep_irq,
    // hub interrupt endpoint
    input wire logic i_hub_in_token,
    input wire logic i_hub_report_sent,
    input wire logic [4:0] i_port_change,
    output usb_ep_hub_pkg::hs_type o_hub_hs,
    output logic [7:0] o_hub_report,
    // bus state
    input wire logic i_suspended,
    input wire logic i_upstream_resume,
    input wire logic i_downstream_resume_done,
    input wire logic i_set_config_zero,
    input wire logic i_transaction_start,
    output logic o_use_new_address,
    output logic o_remote_wakeup_enable,
    output logic o_configured
);
    import usb_ep_hub_pkg::*;

    // only the two function endpoints have register slots
    if (NUM_EP != 2) begin : g_num_ep_check
        $error("only two function endpoints are supported");
    end

    // per-endpoint stored control bits and status flags
    logic [1:0] tx_rdy_reg;
    logic [1:0] halt_reg;
    logic [1:0] last_reg;
    logic [1:0] txc_reg;
    logic [1:0] rxo_reg;
    logic [1:0] stl_reg;
    logic [1:0] tx_rdy_clr; // hardware clearing tx ready this cycle
    // global state bits
    logic wake_en_reg;
    logic config_reg;
    logic addr_en_reg;
    logic addr_live_reg; // address enable as seen by the engine
    logic resume_reg;
    // hub power status bits
    logic [3:0] hub_stat_reg;
    logic [7:0] hub_report_reg;
    logic hub_pending_reg;
    logic irq_reg;
    logic [31:0] prdata_reg;

    // byte address of an index
    function automatic logic [ADDR_W-1:0] byte_addr(input logic [15:0] idx);
        byte_addr = {idx, 2'b00};
    endfunction

    // one-cycle write strobes, taken at the access phase
    logic wr_en;
    logic wr_ep1;
    logic wr_ep2;
    logic wr_hub;
    logic wr_glb;
    logic [7:0] wd;
    logic [1:0] wr_ep;
    logic hit;
    assign wr_en = i_psel && i_penable && i_pwrite;
    assign wd = i_pwdata[7:0];
    assign wr_ep1 = wr_en && (i_paddr == byte_addr(IDX_EP1_CTRL));
    assign wr_ep2 = wr_en && (i_paddr == byte_addr(IDX_EP2_CTRL));
    assign wr_hub = wr_en && (i_paddr == byte_addr(IDX_HUB_STAT));
    assign wr_glb = wr_en && (i_paddr == byte_addr(IDX_HUB_GLOBAL_STATE));
    assign wr_ep = {wr_ep2, wr_ep1};
    assign hit = (i_paddr == byte_addr(IDX_EP1_CTRL)) || (i_paddr == byte_addr(IDX_EP2_CTRL))
        || (i_paddr == byte_addr(IDX_HUB_STAT)) || (i_paddr == byte_addr(IDX_HUB_GLOBAL_STATE))
        || (i_paddr == byte_addr(IDX_EP1_STAT)) || (i_paddr == byte_addr(IDX_EP2_STAT));

    // zero wait state slave; unmapped addresses answer with an error
    assign o_pready = 1'b1;
    assign o_pslverr = i_psel && i_penable && !hit;

    // hardware clear of tx ready: ack from host, or iso sent with no host ack
    assign tx_rdy_clr = i_ep_in_acked | (i_ep_iso & i_ep_iso_sent);

    // endpoint control bits; status bits are read only and ignore writes
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            tx_rdy_reg <= '0;
            halt_reg <= '0;
            last_reg <= '0;
        end else begin
            for (int e = 0; e < 2; e++) begin
                if (wr_ep[e]) begin
                    halt_reg[e] <= wd[CTL_HALT];
                    last_reg[e] <= wd[CTL_LAST];
                end
                // hardware clear wins over a late firmware set: the packet left already
                if (tx_rdy_clr[e]) begin
                    tx_rdy_reg[e] <= 1'b0;
                end else if (wr_ep[e]) begin
                    tx_rdy_reg[e] <= wd[CTL_TX_RDY];
                end
            end
        end
    end

    // status flags: event set wins over the acknowledge pulse
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            txc_reg <= '0;
            rxo_reg <= '0;
            stl_reg <= '0;
        end else begin
            for (int e = 0; e < 2; e++) begin
                // ack bits are consumed here and never stored
                if (i_ep_out_stored[e]) begin
                    rxo_reg[e] <= 1'b1;
                end else if (wr_ep[e] && wd[CTL_RXO_ACK]) begin
                    rxo_reg[e] <= 1'b0;
                end
                if (tx_rdy_clr[e] && tx_rdy_reg[e]) begin
                    txc_reg[e] <= 1'b1;
                end else if (wr_ep[e] && wd[CTL_TXC_ACK]) begin
                    txc_reg[e] <= 1'b0;
                end
                if (i_ep_stall_sent[e]) begin
                    stl_reg[e] <= 1'b1;
                end else if (wr_ep[e] && wd[CTL_STL_ACK]) begin
                    stl_reg[e] <= 1'b0;
                end
            end
        end
    end

    // fifo receive write allowed only while released, or for an early setup
    assign o_ep_fifo_wr_en = ~rxo_reg | {2{i_early_setup}};
    assign o_ep_tx_ready = tx_rdy_reg;
    assign o_ep_last_packet = last_reg;

    // handshake choice per endpoint: stall over nak over ack
    function automatic hs_type ep_hs(input logic out_t, input logic in_t, input logic halt,
                                     input logic rxo, input logic txr);
        ep_hs = HS_NONE;
        if (out_t || in_t) begin
            if (halt) begin
                ep_hs = HS_STALL;
            end else if (out_t) begin
                ep_hs = rxo ? HS_NAK : HS_ACK;
            end else begin
                ep_hs = txr ? HS_NONE : HS_NAK; // data phase when ready
            end
        end
    endfunction

    assign o_ep1_hs = ep_hs(i_ep_out_token[0], i_ep_in_token[0], halt_reg[0], rxo_reg[0],
                            tx_rdy_reg[0]);
    assign o_ep2_hs = ep_hs(i_ep_out_token[1], i_ep_in_token[1], halt_reg[1], rxo_reg[1],
                            tx_rdy_reg[1]);

    // interrupt pulse when hardware drops tx ready with complete already set
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            irq_reg <= 1'b0;
        end else begin
            irq_reg <= |(tx_rdy_clr & tx_rdy_reg & txc_reg & i_ep_irq_en);
        end
    end
    assign o_ep_irq = irq_reg;

    // global state: firmware bits, suspend mirror, resume hold
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            wake_en_reg <= 1'b0;
            config_reg <= 1'b0;
            addr_en_reg <= 1'b0;
        end else begin
            if (wr_glb) begin
                wake_en_reg <= wd[GS_WAKE_EN];
                addr_en_reg <= wd[GS_ADDR_EN];
            end
            if (i_set_config_zero) begin
                config_reg <= 1'b0;
            end else if (wr_glb) begin
                config_reg <= wd[GS_CONFIG];
            end
        end
    end

    // new address takes effect only at a transaction boundary
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            addr_live_reg <= 1'b0;
        end else if (i_transaction_start) begin
            addr_live_reg <= addr_en_reg;
        end
    end

    // resume flag held from upstream resume until downstream resume completes
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            resume_reg <= 1'b0;
        end else if (i_upstream_resume) begin
            resume_reg <= 1'b1;
        end else if (i_downstream_resume_done) begin
            resume_reg <= 1'b0;
        end
    end

    // hub power status: firmware maintained, all four bits writable
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            hub_stat_reg <= RESET_VALUE[3:0];
        end else if (wr_hub) begin
            hub_stat_reg <= wd[3:0];
        end
    end

    // hub interrupt endpoint: report built in hardware, naks when idle
    logic [7:0] report_now;
    assign report_now = {2'b00, i_port_change,
                         hub_stat_reg[HS_OVI] | hub_stat_reg[HS_OVC]};
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            hub_report_reg <= '0;
            hub_pending_reg <= 1'b0;
        end else begin
            hub_report_reg <= report_now;
            if (|report_now) begin
                hub_pending_reg <= 1'b1;
            end else if (i_hub_report_sent) begin
                hub_pending_reg <= 1'b0;
            end
        end
    end
    assign o_hub_report = hub_report_reg;
    assign o_hub_hs = !i_hub_in_token ? HS_NONE : (hub_pending_reg ? HS_NONE : HS_NAK);

    assign o_use_new_address = addr_live_reg;
    assign o_remote_wakeup_enable = wake_en_reg;
    assign o_configured = config_reg;

    // read mux; reserved bits and pulse bits read zero
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            prdata_reg <= '0;
        end else begin
            prdata_reg <= '0;
            if (i_psel && !i_penable && !i_pwrite) begin
                unique case (i_paddr)
                    byte_addr(IDX_EP1_CTRL): begin
                        prdata_reg[6:4] <= {last_reg[0], halt_reg[0], tx_rdy_reg[0]};
                    end
                    byte_addr(IDX_EP2_CTRL): begin
                        prdata_reg[6:4] <= {last_reg[1], halt_reg[1], tx_rdy_reg[1]};
                    end
                    byte_addr(IDX_EP1_STAT): begin
                        prdata_reg[3:0] <= {stl_reg[0], 1'b0, rxo_reg[0], txc_reg[0]};
                    end
                    byte_addr(IDX_EP2_STAT): begin
                        prdata_reg[3:0] <= {stl_reg[1], 1'b0, rxo_reg[1], txc_reg[1]};
                    end
                    byte_addr(IDX_HUB_STAT): prdata_reg[3:0] <= hub_stat_reg;
                    // suspend is a live mirror of the engine state, not a stored copy
                    byte_addr(IDX_HUB_GLOBAL_STATE): begin
                        prdata_reg[4:0] <= {i_suspended, resume_reg, wake_en_reg, config_reg,
                                            addr_en_reg};
                    end
                    default: prdata_reg <= '0;
                endcase
            end
        end
    end
    assign o_prdata = prdata_reg;

    // rx flag never drops without an ack write
    a_rxo_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $fell(rxo_reg[0]) |-> $past(wr_ep1) && $past(wd[CTL_RXO_ACK]))
        else $error("receive flag cleared without ack");
    a_out_nak: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        rxo_reg[0] && i_ep_out_token[0] && !halt_reg[0] |-> o_ep1_hs == HS_NAK)
        else $error("out token not nakked while flag set");
    a_stall_halt: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        halt_reg[1] && i_ep_in_token[1] |-> o_ep2_hs == HS_STALL)
        else $error("halted endpoint did not stall");
    a_rxo_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_ep_out_stored[0] |=> rxo_reg[0])
        else $error("receive flag not set");
    a_stl_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_ep_stall_sent[1] |=> stl_reg[1])
        else $error("stall sent flag not set");
    a_txr_clear: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_ep_in_acked[0] |=> !tx_rdy_reg[0])
        else $error("tx ready not cleared on ack");
    a_resume_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $fell(resume_reg) |-> $past(i_downstream_resume_done))
        else $error("resume flag dropped early");
    a_hub_nak: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_hub_in_token && !hub_pending_reg |-> o_hub_hs == HS_NAK)
        else $error("hub endpoint did not nak");
    // transmit side: complete flag, its acknowledge and the interrupt pulse
    a_txc_set: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        tx_rdy_clr[0] && tx_rdy_reg[0] |=> txc_reg[0])
        else $error("transmit complete not set");
    a_txc_hold: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        $fell(txc_reg[0]) |-> $past(wr_ep1) && $past(wd[CTL_TXC_ACK]))
        else $error("transmit complete cleared without ack");
    a_irq_pulse: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        tx_rdy_clr[0] && tx_rdy_reg[0] && txc_reg[0] && i_ep_irq_en[0] |=> o_ep_irq)
        else $error("no interrupt on ready clear");
    a_fifo_block: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        rxo_reg[0] && !i_early_setup |-> !o_ep_fifo_wr_en[0])
        else $error("fifo write allowed while data held");
    a_addr_wait: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        !i_transaction_start |=> $stable(o_use_new_address))
        else $error("address switched inside a transaction");
    a_cfg_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        i_set_config_zero |=> !o_configured)
        else $error("configured bit survived config zero");
    a_bitmap_bit0: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        hub_stat_reg[HS_OVI] || hub_stat_reg[HS_OVC] |=> o_hub_report[0])
        else $error("hub bitmap bit0 missing");
    a_rsv_zero: assert property (@(posedge i_sys_clk) disable iff (i_rst)
        o_prdata[31:7] == '0)
        else $error("reserved read bits not zero");
endmodule // usb_ep_hub_regs

// ===== dv/usb_host_model.sv
`timescale 1ns/1ps
// behavioural upstream host and serial engine: raises tokens, reacts to handshakes
module usb_host_model
    import usb_ep_hub_pkg::*;
(
    // clock
    input wire logic i_sys_clk,
    // handshakes from the block
    input wire usb_ep_hub_pkg::hs_type i_ep1_hs,
    input wire usb_ep_hub_pkg::hs_type i_ep2_hs,
    input wire usb_ep_hub_pkg::hs_type i_hub_hs,
    input wire logic [1:0] i_iso,
    // token and event strobes to the block
    output logic [1:0] o_out_token,
    output logic [1:0] o_in_token,
    output logic [1:0] o_out_stored,
    output logic [1:0] o_in_acked,
    output logic [1:0] o_iso_sent,
    output logic [1:0] o_stall_sent,
    output logic o_hub_in_token,
    output logic o_hub_report_sent
);
    import usb_ep_hub_pkg::*;
    // idle bus: no token, no event
    initial begin
        {o_out_token, o_in_token, o_out_stored, o_in_acked} = '0;
        {o_iso_sent, o_stall_sent, o_hub_in_token, o_hub_report_sent} = '0;
    end
    // one token to a function endpoint; handshake taken at the edge that drops it
    task automatic ep_token(input int ep, input bit is_in, output hs_type hs);
        @(posedge i_sys_clk);
        if (is_in) o_in_token[ep] <= 1'b1;
        else o_out_token[ep] <= 1'b1;
        @(posedge i_sys_clk);
        hs = (ep == 0) ? i_ep1_hs : i_ep2_hs;
        o_in_token[ep] <= 1'b0;
        o_out_token[ep] <= 1'b0;
        // the engine reports what happened on the wire, nothing kinder
        if (hs == HS_STALL) o_stall_sent[ep] <= 1'b1;
        else if (!is_in && hs == HS_ACK) o_out_stored[ep] <= 1'b1;
        else if (is_in && hs != HS_NAK && i_iso[ep]) o_iso_sent[ep] <= 1'b1;
        else if (is_in && hs != HS_NAK) o_in_acked[ep] <= 1'b1;
        @(posedge i_sys_clk);
        {o_out_stored, o_in_acked, o_iso_sent, o_stall_sent} <= '0;
    endtask
    // one token to the hub status endpoint; no handshake means a report went out
    task automatic hub_token(output hs_type hs);
        @(posedge i_sys_clk);
        o_hub_in_token <= 1'b1;
        @(posedge i_sys_clk);
        hs = i_hub_hs;
        o_hub_in_token <= 1'b0;
        o_hub_report_sent <= (hs == HS_NONE);
        @(posedge i_sys_clk);
        o_hub_report_sent <= 1'b0;
    endtask
endmodule // usb_host_model

// ===== dv/testbench.sv
`timescale 1ns/1ps
module testbench;
    import usb_ep_hub_pkg::*;
    logic i_sys_clk, i_rst, i_psel, i_penable, i_pwrite;
    logic [ADDR_W-1:0] i_paddr;
    logic [31:0] i_pwdata, o_prdata;
    logic o_pready, o_pslverr, irq, hub_tok, hub_sent;
    logic [1:0] tok_o, tok_i, iso, stored, acked, iso_sent, stall_sent, irq_en, tx_rdy, last;
    hs_type hs1, hs2, hub_hs, h;
    logic [4:0] port_chg;
    logic susp, up_res, dn_done, cfg0, new_addr, wake_en, configured;
    int err_count = 0, samples_checked = 0, cyc = 0, irq_cnt = 0, n;
    logic [31:0] d;
    logic e, tstart, early;
    logic [1:0] fifo_wr;
    logic [7:0] hub_rep;
    // register map, all reset to zero
    logic [15:0] regs [6] = '{IDX_EP1_CTRL, IDX_EP2_CTRL, IDX_EP1_STAT, IDX_EP2_STAT,
        IDX_HUB_STAT, IDX_HUB_GLOBAL_STATE};
    usb_ep_hub_regs i_dut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_psel(i_psel),
        .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
        .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr),
        .i_ep_out_token(tok_o), .i_ep_in_token(tok_i), .i_ep_iso(iso),
        .i_ep_out_stored(stored), .i_ep_in_acked(acked), .i_ep_iso_sent(iso_sent),
        .i_ep_stall_sent(stall_sent), .i_ep_irq_en(irq_en), .i_early_setup(early),
        .o_ep1_hs(hs1), .o_ep2_hs(hs2), .o_ep_fifo_wr_en(fifo_wr), .o_ep_tx_ready(tx_rdy),
        .o_ep_last_packet(last), .o_ep_irq(irq), .i_hub_in_token(hub_tok),
        .i_hub_report_sent(hub_sent), .i_port_change(port_chg), .o_hub_hs(hub_hs),
        .o_hub_report(hub_rep), .i_suspended(susp), .i_upstream_resume(up_res),
        .i_downstream_resume_done(dn_done), .i_set_config_zero(cfg0),
        .i_transaction_start(tstart), .o_use_new_address(new_addr),
        .o_remote_wakeup_enable(wake_en), .o_configured(configured));
    usb_host_model i_host (.i_sys_clk(i_sys_clk), .i_ep1_hs(hs1), .i_ep2_hs(hs2),
        .i_hub_hs(hub_hs), .i_iso(iso), .o_out_token(tok_o), .o_in_token(tok_i),
        .o_out_stored(stored), .o_in_acked(acked), .o_iso_sent(iso_sent),
        .o_stall_sent(stall_sent), .o_hub_in_token(hub_tok), .o_hub_report_sent(hub_sent));
    // 40 mhz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    // count interrupt pulses; a pulse lasts one cycle so it is caught here, not by polling
    always @(posedge i_sys_clk) begin
        if (irq === 1'b1) irq_cnt++;
        cyc++;
        // a hang ends the run as a failure
        if (cyc == 8000) begin
            err_count++;
            summarize();
        end
    end
    task automatic summarize();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic chk8(input string nm, input logic [7:0] ex, input logic [7:0] got);
        samples_checked++;
        if (got !== ex) begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task automatic chkhs(input string nm, input hs_type ex, input hs_type got);
        samples_checked++;
        if (got !== ex) begin
            err_count++;
            $display("wrong value %s expected %0d seen %0d", nm, ex, got);
        end
    endtask
    // one apb transfer: setup, then access held until pready is seen at an edge
    task automatic apb(input logic w, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge i_sys_clk);
        i_psel <= 1'b1;
        i_pwrite <= w;
        i_paddr <= {idx, 2'b00};
        i_pwdata <= {24'h0, wd};
        @(posedge i_sys_clk);
        i_penable <= 1'b1;
        do @(posedge i_sys_clk); while (o_pready !== 1'b1);
        d = o_prdata;
        e = o_pslverr;
        i_psel <= 1'b0;
        i_penable <= 1'b0;
    endtask
    task automatic wr(input logic [15:0] idx, input logic [7:0] v);
        apb(1'b1, idx, v);
    endtask
    task automatic rd(input string nm, input logic [15:0] idx, input logic [7:0] ex);
        apb(1'b0, idx, 8'h00);
        chk8(nm, ex, d[7:0]);
    endtask
    initial begin
        {i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = '0;
        {iso, irq_en, port_chg, susp, up_res, dn_done, cfg0, tstart, early} = '0;
        i_rst = 1'b1;
        repeat (5) @(posedge i_sys_clk);
        i_rst <= 1'b0;
        foreach (regs[k]) rd("reset_value", regs[k], 8'h00);
        apb(1'b0, 16'h0100, 8'h00);
        chk8("unmapped", 8'h01, {7'h0, e});
        // receive path on endpoint 1
        i_host.ep_token(0, 1'b0, h);
        chkhs("ep1_out_hs", HS_ACK, h);
        rd("ep1_stat", IDX_EP1_STAT, 8'h02);
        i_host.ep_token(0, 1'b0, h);
        chkhs("ep1_out_busy", HS_NAK, h);
        rd("ep1_stat", IDX_EP1_STAT, 8'h02);
        chk8("fifo_block", 8'h00, {7'h0, fifo_wr[0]});
        early <= 1'b1;
        @(posedge i_sys_clk);
        chk8("fifo_setup", 8'h01, {7'h0, fifo_wr[0]});
        early <= 1'b0;
        wr(IDX_EP1_CTRL, 8'h02);
        rd("ep1_stat", IDX_EP1_STAT, 8'h00);
        rd("ep1_ctrl", IDX_EP1_CTRL, 8'h00);
        // transmit path; ready is set only while it reads zero
        irq_en <= 2'b01;
        wr(IDX_EP1_CTRL, 8'h50);
        @(posedge i_sys_clk);
        chk8("ready_last", 8'h03, {tx_rdy[0], last[0]});
        i_host.ep_token(0, 1'b1, h);
        rd("ep1_stat", IDX_EP1_STAT, 8'h01);
        rd("ep1_ctrl", IDX_EP1_CTRL, 8'h40);
        n = irq_cnt;
        wr(IDX_EP1_CTRL, 8'h50);
        i_host.ep_token(0, 1'b1, h);
        rd("ep1_stat", IDX_EP1_STAT, 8'h01);
        chk8("irq_pulses", 8'h01, 8'(irq_cnt - n));
        wr(IDX_EP1_CTRL, 8'h41);
        rd("ep1_stat", IDX_EP1_STAT, 8'h00);
        // halt on endpoint 2 stalls both directions
        wr(IDX_EP2_CTRL, 8'h20);
        i_host.ep_token(1, 1'b0, h);
        chkhs("ep2_out_halt", HS_STALL, h);
        i_host.ep_token(1, 1'b1, h);
        chkhs("ep2_in_halt", HS_STALL, h);
        rd("ep2_stat", IDX_EP2_STAT, 8'h08);
        wr(IDX_EP2_CTRL, 8'h28);
        rd("ep2_stat", IDX_EP2_STAT, 8'h00);
        rd("ep2_ctrl", IDX_EP2_CTRL, 8'h20);
        // isochronous: ready drops once sent, no host ack
        iso <= 2'b10;
        wr(IDX_EP2_CTRL, 8'h10);
        i_host.ep_token(1, 1'b1, h);
        rd("ep2_iso_ctrl", IDX_EP2_CTRL, 8'h00);
        // hub status endpoint: nothing pending, then a port change
        i_host.hub_token(h);
        chkhs("hub_idle", HS_NAK, h);
        port_chg <= 5'h02;
        repeat (2) @(posedge i_sys_clk);
        i_host.hub_token(h);
        chkhs("hub_report", HS_NONE, h);
        port_chg <= 5'h00;
        // hub power status and global state, read-only and reserved bits ignored
        wr(IDX_HUB_STAT, 8'hff);
        rd("hub_stat", IDX_HUB_STAT, 8'h0f);
        wr(IDX_HUB_STAT, 8'h08);
        repeat (2) @(posedge i_sys_clk);
        chk8("hub_bitmap", 8'h01, hub_rep);
        wr(IDX_HUB_STAT, 8'h00);
        wr(IDX_HUB_GLOBAL_STATE, 8'hff);
        rd("glb", IDX_HUB_GLOBAL_STATE, 8'h07);
        chk8("addr_held", 8'h00, {7'h0, new_addr});
        tstart <= 1'b1;
        @(posedge i_sys_clk);
        tstart <= 1'b0;
        @(posedge i_sys_clk);
        chk8("glb_outs", 8'h07, {5'h0, wake_en, configured, new_addr});
        susp <= 1'b1;
        rd("glb_susp", IDX_HUB_GLOBAL_STATE, 8'h17);
        up_res <= 1'b1;
        @(posedge i_sys_clk);
        up_res <= 1'b0;
        rd("glb_resume", IDX_HUB_GLOBAL_STATE, 8'h1f);
        dn_done <= 1'b1;
        cfg0 <= 1'b1;
        @(posedge i_sys_clk);
        {dn_done, cfg0} <= 2'b00;
        susp <= 1'b0;
        rd("glb_done", IDX_HUB_GLOBAL_STATE, 8'h05);
        summarize();
    end
endmodule // testbench
